// ---- core/fsrb_field_sensor_register_bank.sv ----
`timescale 1ns/1ns
module fsrb_field_sensor_register_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_req_valid,
  input wire fsrb_pkg::fsrb_req_t link_req,
  output logic link_busy,
  output logic link_rsp_valid,
  output logic [31:0] link_rdata,
  input wire logic unlock_active,
  input wire logic sample_valid,
  input wire fsrb_pkg::fsrb_sample_t sample_in,
  input wire logic event_level,
  input wire logic event_hold_en,
  input wire logic event_record_en,
  input wire logic persist_write_done,
  output logic persist_write_start,
  output logic event_pin_n,
  output logic [2:0] inactive_count_sel,
  output logic [1:0] loop_mode,
  output logic mode_active,
  output logic mode_sleep,
  output logic duty_cycled_low_power_operation
);

  // ---------------- link domain ----------------
  fsrb_pkg::fsrb_req_t lreq_r;
  logic lreq_tgl_r;
  logic lack_s1_r;
  logic lack_s2_r;
  logic lack_s3_r;
  logic lbusy_r;
  logic lrsp_r;
  logic [31:0] lrdata_r;

  // core-domain signals declared early for the crossing
  logic creq_s1_r;
  logic creq_s2_r;
  logic creq_s3_r;
  logic cack_tgl_r;
  logic [31:0] crdata_r;

  wire link_take = link_req_valid & ~lbusy_r; // requests while busy are dropped
  wire link_ack_edge = lack_s2_r ^ lack_s3_r;

  // request is held stable in lreq_r until the core acknowledges it
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lreq_r <= '0;
      lreq_tgl_r <= 1'b0;
      lbusy_r <= 1'b0;
    end else begin
      if (link_take) begin
        lreq_r <= link_req;
        lreq_tgl_r <= ~lreq_tgl_r;
        lbusy_r <= 1'b1;
      end else if (link_ack_edge) begin
        lbusy_r <= 1'b0;
      end
    end
  end

  // acknowledge toggle comes back through two flops; third is for edge only
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lack_s1_r <= 1'b0;
      lack_s2_r <= 1'b0;
      lack_s3_r <= 1'b0;
    end else begin
      lack_s1_r <= cack_tgl_r;
      lack_s2_r <= lack_s1_r;
      lack_s3_r <= lack_s2_r;
    end
  end

  // response pulse, one link cycle per acknowledge edge
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lrsp_r <= 1'b0;
    end else begin
      lrsp_r <= link_ack_edge;
    end
  end

  // read data is already stable in crdata_r when the ack edge arrives
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lrdata_r <= 32'h00000000;
    end else if (link_ack_edge) begin
      lrdata_r <= crdata_r;
    end
  end

  assign link_busy = lbusy_r;
  assign link_rsp_valid = lrsp_r;
  assign link_rdata = lrdata_r;

  // ---------------- core domain ----------------
  logic [25:0] user_r [3];
  logic [2:0] inact_r;
  logic [1:0] loop_r;
  logic [1:0] pmode_r;
  fsrb_pkg::fsrb_sample_t samp_r;
  logic new_r;
  logic evt_r;
  logic persist_busy_r;
  logic persist_start_r;
  logic evt_level_d_r;
  logic evt_pin_n_r;
  logic mode_act_r;
  logic mode_slp_r;
  logic mode_duty_r;

  // request toggle synchroniser, first flop read only by the second
  always_ff @(posedge clock) begin
    if (rst) begin
      creq_s1_r <= 1'b0;
      creq_s2_r <= 1'b0;
      creq_s3_r <= 1'b0;
    end else if (clock_enable) begin
      creq_s1_r <= lreq_tgl_r;
      creq_s2_r <= creq_s1_r;
      creq_s3_r <= creq_s2_r;
    end
  end

  // lreq_r is stable once the toggle has passed two flops
  wire acc_go = clock_enable & (creq_s2_r ^ creq_s3_r);
  wire acc_wr = acc_go & lreq_r.write;
  wire acc_rd = acc_go & ~lreq_r.write;
  wire [7:0] acc_addr = lreq_r.addr;
  wire [31:0] acc_wdata = lreq_r.wdata;

  // offset match, shared by every strobe and the read mux
  function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // address decode
  wire hit_ua = ofs_hit(acc_addr, fsrb_pkg::OFS_USER_A);
  wire hit_ub = ofs_hit(acc_addr, fsrb_pkg::OFS_USER_B);
  wire hit_uc = ofs_hit(acc_addr, fsrb_pkg::OFS_USER_C);
  wire hit_ctrl = ofs_hit(acc_addr, fsrb_pkg::OFS_CTRL);
  wire hit_hi = ofs_hit(acc_addr, fsrb_pkg::OFS_SAMPLE_HI);
  wire hit_lo = ofs_hit(acc_addr, fsrb_pkg::OFS_SAMPLE_LO);

  // locked writes only reach the power mode field
  wire wr_unlocked = acc_wr & unlock_active;
  wire wr_user_a = wr_unlocked & hit_ua;
  wire wr_user_b = wr_unlocked & hit_ub;
  wire wr_user_c = wr_unlocked & hit_uc;
  wire wr_ctrl_full = wr_unlocked & hit_ctrl;
  wire wr_pmode = acc_wr & hit_ctrl;
  wire evt_w1c = wr_unlocked & hit_hi & acc_wdata[fsrb_pkg::HI_EVT_BIT];
  wire rd_hi = acc_rd & hit_hi;

  // sample word assembly; reserved bits tied to zero
  wire [31:0] hi_word = {samp_r.x[11:4], samp_r.y[11:4], samp_r.z[11:4],
                         new_r, evt_r,
                         samp_r.temp[11:6]};
  wire [31:0] lo_word = {11'h000, persist_busy_r,
                         samp_r.x[3:0], samp_r.y[3:0], samp_r.z[3:0],
                         samp_r.hall_mode,
                         samp_r.temp[5:0]};
  wire [31:0] ctrl_word = {25'h0000000, inact_r, loop_r, pmode_r};

  // read mux, no lock check on reads; unmapped offsets read zero
  wire [31:0] rd_mux = hit_ua ? {6'h00, user_r[0]} :
                       hit_ub ? {6'h00, user_r[1]} :
                       hit_uc ? {6'h00, user_r[2]} :
                       hit_ctrl ? ctrl_word :
                       hit_hi ? hi_word :
                       hit_lo ? lo_word :
                       32'h00000000;

  // read data capture and acknowledge toggle; writes also acknowledge
  always_ff @(posedge clock) begin
    if (rst) begin
      crdata_r <= 32'h00000000;
      cack_tgl_r <= 1'b0;
    end else if (acc_go) begin
      crdata_r <= rd_mux;
      cack_tgl_r <= ~cack_tgl_r;
    end
  end

  // user storage words, plain storage with no path into device behaviour
  always_ff @(posedge clock) begin
    if (rst) begin
      user_r[0] <= fsrb_pkg::USER_RST;
      user_r[1] <= fsrb_pkg::USER_RST;
      user_r[2] <= fsrb_pkg::USER_RST;
    end else if (clock_enable) begin
      if (wr_user_a) user_r[0] <= acc_wdata[fsrb_pkg::USER_W-1:0];
      if (wr_user_b) user_r[1] <= acc_wdata[fsrb_pkg::USER_W-1:0];
      if (wr_user_c) user_r[2] <= acc_wdata[fsrb_pkg::USER_W-1:0];
    end
  end

  // control word fields that only an unlocked write reaches
  always_ff @(posedge clock) begin
    if (rst) begin
      inact_r <= fsrb_pkg::INACT_RST;
      loop_r <= fsrb_pkg::LOOP_RST;
    end else if (clock_enable & wr_ctrl_full) begin
      inact_r <= acc_wdata[fsrb_pkg::INACT_LSB +: 3];
      loop_r <= acc_wdata[fsrb_pkg::LOOP_LSB +: 2];
    end
  end

  // power mode field, writable whether locked or not
  always_ff @(posedge clock) begin
    if (rst) begin
      pmode_r <= fsrb_pkg::PMODE_RST;
    end else if (clock_enable & wr_pmode) begin
      pmode_r <= acc_wdata[fsrb_pkg::PMODE_LSB +: 2];
    end
  end

  // power code decode, shared by the three mode strobes
  function automatic logic pm_is(input logic [1:0] code, input fsrb_pkg::fsrb_pmode_t mode);
    return code == mode;
  endfunction

  // code 3 is undefined; it decodes to no mode so nothing starts by accident
  wire [1:0] pmode_nxt = wr_pmode ? acc_wdata[fsrb_pkg::PMODE_LSB +: 2] : pmode_r;
  wire dec_act = pm_is(pmode_nxt, fsrb_pkg::FSRB_PM_ACTIVE);
  wire dec_slp = pm_is(pmode_nxt, fsrb_pkg::FSRB_PM_SLEEP);
  wire dec_duty = pm_is(pmode_nxt, fsrb_pkg::FSRB_PM_DUTY);

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_act_r <= 1'b1;
      mode_slp_r <= 1'b0;
      mode_duty_r <= 1'b0;
    end else if (clock_enable) begin
      mode_act_r <= dec_act;
      mode_slp_r <= dec_slp;
      mode_duty_r <= dec_duty;
    end
  end

  // whole measurement loads in one edge; a sample arriving between the hi and lo reads still replaces it
  always_ff @(posedge clock) begin
    if (rst) begin
      samp_r <= '0;
    end else if (clock_enable & sample_valid) begin
      samp_r <= sample_in;
    end
  end

  // fresh-sample flag: a sample arriving with the read keeps the flag set
  wire new_nxt = (clock_enable & sample_valid) | (new_r & ~rd_hi);

  // event flag follows the level unless held; the set beats the clear
  wire evt_nxt = event_hold_en ? (event_level | (evt_r & ~evt_w1c))
                               : event_level;

  // fresh-sample flag register
  always_ff @(posedge clock) begin
    if (rst) begin
      new_r <= 1'b0;
    end else if (clock_enable) begin
      new_r <= new_nxt;
    end
  end

  // event status flag register
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_r <= 1'b0;
    end else if (clock_enable) begin
      evt_r <= evt_nxt;
    end
  end

  // pin comes from the same next value, so it never lags the status flag
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_pin_n_r <= 1'b1;
    end else if (clock_enable) begin
      evt_pin_n_r <= ~evt_nxt;
    end
  end

  // persistent record: one write per rising event while not busy, busy until done returns
  wire evt_rise = event_level & ~evt_level_d_r;
  wire persist_go = evt_rise & event_record_en & ~persist_busy_r;

  // level history for the edge detector, and the one-cycle start pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_level_d_r <= 1'b0;
      persist_start_r <= 1'b0;
    end else if (clock_enable) begin
      evt_level_d_r <= event_level;
      persist_start_r <= persist_go;
    end
  end

  // busy from the start until the done pulse; a new start wins over a done
  always_ff @(posedge clock) begin
    if (rst) begin
      persist_busy_r <= 1'b0;
    end else if (clock_enable) begin
      if (persist_go) begin
        persist_busy_r <= 1'b1;
      end else if (persist_write_done) begin
        persist_busy_r <= 1'b0;
      end
    end
  end

  assign persist_write_start = persist_start_r;
  assign event_pin_n = evt_pin_n_r;
  assign inactive_count_sel = inact_r;
  assign loop_mode = loop_r;
  assign mode_active = mode_act_r;
  assign mode_sleep = mode_slp_r;
  assign duty_cycled_low_power_operation = mode_duty_r;

endmodule // fsrb_field_sensor_register_bank

// ---- core/fsrb_pkg.sv ----
package fsrb_pkg;

  // register offsets as seen through the register access port
  localparam logic [7:0] OFS_USER_A = 8'h0d;
  localparam logic [7:0] OFS_USER_B = 8'h0e;
  localparam logic [7:0] OFS_USER_C = 8'h0f;
  localparam logic [7:0] OFS_CTRL = 8'h27;
  localparam logic [7:0] OFS_SAMPLE_HI = 8'h28;
  localparam logic [7:0] OFS_SAMPLE_LO = 8'h29;

  // field layout
  localparam int USER_W = 26;
  localparam int INACT_LSB = 4;
  localparam int LOOP_LSB = 2;
  localparam int PMODE_LSB = 0;
  localparam int HI_X_LSB = 24;
  localparam int HI_Y_LSB = 16;
  localparam int HI_Z_LSB = 8;
  localparam int HI_NEW_BIT = 7;
  localparam int HI_EVT_BIT = 6;
  localparam int LO_PERSIST_BIT = 20;
  localparam int LO_X_LSB = 16;
  localparam int LO_Y_LSB = 12;
  localparam int LO_Z_LSB = 8;
  localparam int LO_HALL_LSB = 6;
  localparam int TEMP_HALF_W = 6;

  // reset values
  localparam logic [25:0] USER_RST = 26'h0000000;
  localparam logic [2:0] INACT_RST = 3'h0;
  localparam logic [1:0] LOOP_RST = 2'h0;
  localparam logic [1:0] PMODE_RST = 2'h0;

  // power mode select codes
  typedef enum logic [1:0] {
    FSRB_PM_ACTIVE = 2'b00,
    FSRB_PM_SLEEP = 2'b01,
    FSRB_PM_DUTY = 2'b10
  } fsrb_pmode_t;

  // one complete measurement, loaded as a unit
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] temp;
    logic [1:0] hall_mode;
  } fsrb_sample_t;

  // register access request from the link-side engine
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } fsrb_req_t;

endpackage

// ---- testbench/fsrb_monitor.sv ----
`timescale 1ns/1ns
module fsrb_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_req_valid,
  input wire logic link_busy,
  input wire logic link_rsp_valid,
  input wire logic unlock_active,
  input wire logic event_level,
  input wire logic event_hold_en,
  input wire logic event_record_en,
  input wire logic persist_write_start,
  input wire logic event_pin_n,
  input wire logic [2:0] inactive_count_sel,
  input wire logic [1:0] loop_mode,
  input wire logic mode_active,
  input wire logic mode_sleep,
  input wire logic duty_cycled_low_power_operation
);
  // core side: mode decode, event flag, persistent-write start pulse and locked control fields
  a_mode_onehot: assert property (@(posedge clock) disable iff (rst)
    $onehot0({mode_active, mode_sleep, duty_cycled_low_power_operation}))
    else $error("several modes at once");
  a_reset_state: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> mode_active && event_pin_n) else $error("bad state after reset");
  a_unheld_follow: assert property (@(posedge clock) disable iff (rst)
    clock_enable && !event_hold_en |=> event_pin_n == !$past(event_level))
    else $error("event pin does not follow level");
  a_held_set: assert property (@(posedge clock) disable iff (rst)
    clock_enable && event_hold_en && event_level |=> !event_pin_n) else $error("event not held");
  a_start_pulse: assert property (@(posedge clock) disable iff (rst)
    persist_write_start |=> !persist_write_start) else $error("start longer than a cycle");
  a_start_cause: assert property (@(posedge clock) disable iff (rst)
    persist_write_start |-> $past(event_record_en) && $past(event_level))
    else $error("start without recorded event");
  a_ctl_locked: assert property (@(posedge clock) disable iff (rst)
    !$stable({inactive_count_sel, loop_mode}) |-> $past(unlock_active))
    else $error("control field changed while locked");
  // link side: one outstanding access, bounded answer, one-cycle response
  a_take_busy: assert property (@(posedge link_clk) disable iff (link_rst)
    link_req_valid && !link_busy |=> link_busy) else $error("request not taken");
  a_rsp_bound: assert property (@(posedge link_clk) disable iff (link_rst)
    link_req_valid && !link_busy |-> ##[2:17] link_rsp_valid) else $error("no response");
  a_rsp_pulse: assert property (@(posedge link_clk) disable iff (link_rst)
    link_rsp_valid |-> !link_busy ##1 !link_rsp_valid) else $error("bad response pulse");
endmodule // fsrb_monitor

bind fsrb_field_sensor_register_bank fsrb_monitor mon_u (.clock, .rst, .clock_enable,
  .link_clk, .link_rst, .link_req_valid, .link_busy, .link_rsp_valid, .unlock_active,
  .event_level, .event_hold_en, .event_record_en, .persist_write_start, .event_pin_n,
  .inactive_count_sel, .loop_mode, .mode_active, .mode_sleep, .duty_cycled_low_power_operation);

// ---- testbench/fsrb_host_model.sv ----
`timescale 1ns/1ns
module fsrb_host_model (
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_rsp_valid,
  input wire logic [31:0] link_rdata,
  output logic link_req_valid,
  output fsrb_pkg::fsrb_req_t link_req
);
  initial begin
    link_req_valid = 1'h0;
    link_req = '0;
  end

  // one access at a time; released lines go inverse so stale values never look valid
  task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    q = 'x;
    @(posedge link_clk);
    link_req_valid <= 1'h1;
    link_req <= '{addr: a, write: w, wdata: d};
    @(posedge link_clk);
    while (link_busy !== 1'h0) @(posedge link_clk);
    link_req_valid <= 1'h0;
    link_req <= ~link_req;
    while (link_rsp_valid !== 1'h1 && n < 40) begin
      @(posedge link_clk);
      n++;
    end
    if (link_rsp_valid === 1'h1) q = link_rdata; // a lost answer leaves q unknown
  endtask

  // both sample words back to back, as two separate single-word accesses
  task automatic read_sample(output logic [31:0] hi, output logic [31:0] lo);
    access(8'h28, 1'h0, 32'h0, hi);
    access(8'h29, 1'h0, 32'h0, lo);
  endtask
endmodule // fsrb_host_model

// ---- testbench/fsrb_field_sensor_register_bank_tb_top.sv ----
`timescale 1ns/1ns
module fsrb_field_sensor_register_bank_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic u;
    logic [31:0] d;
    logic [31:0] e;
  } fsrb_row_t;
  logic clock = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic clock_enable = 1'h1;
  logic unlock_active = 1'h0;
  logic sample_valid = 1'h0;
  logic event_level = 1'h0;
  logic event_hold_en = 1'h0;
  logic event_record_en = 1'h0;
  logic persist_write_done = 1'h0;
  fsrb_pkg::fsrb_sample_t sample_in = '0;
  fsrb_pkg::fsrb_sample_t s;
  fsrb_pkg::fsrb_req_t link_req;
  logic link_req_valid, link_busy, link_rsp_valid, persist_write_start, event_pin_n;
  logic mode_active, mode_sleep, duty_cycled_low_power_operation;
  logic [1:0] loop_mode;
  logic [2:0] inactive_count_sel;
  logic [31:0] link_rdata, q, hi, lo;
  int error_cnt = 0;
  int n_tests = 0;
  int n_start = 0;
  fsrb_row_t rows [9];

  // link clock offset so the two domains never line up
  always #25 clock = ~clock;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // counts start pulses so a missing or doubled persistent write shows up
  always @(posedge clock) begin
    if (persist_write_start === 1'h1) n_start <= n_start + 1;
  end

  fsrb_field_sensor_register_bank dut_u (.clock, .rst, .clock_enable, .link_clk,
    .link_rst(rst), .link_req_valid, .link_req, .link_busy, .link_rsp_valid, .link_rdata,
    .unlock_active, .sample_valid, .sample_in, .event_level, .event_hold_en, .event_record_en,
    .persist_write_done, .persist_write_start, .event_pin_n, .inactive_count_sel, .loop_mode,
    .mode_active, .mode_sleep, .duty_cycled_low_power_operation);
  fsrb_host_model host_u (.link_clk, .link_busy, .link_rsp_valid, .link_rdata,
    .link_req_valid, .link_req);

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // unlock is held steady around the whole access so the core edge sees one value
  task automatic acc(input logic [7:0] a, input logic w, input logic u, input logic [31:0] d);
    @(posedge clock);
    unlock_active <= u;
    repeat (2) @(posedge clock);
    host_u.access(a, w, d, q);
    repeat (2) @(posedge clock);
    unlock_active <= 1'h0;
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial begin
    rows = '{'{8'h0d, 1'h0, 1'h0, 32'h0, 32'h0}, '{8'h27, 1'h0, 1'h0, 32'h0, 32'h0},
      '{8'h0d, 1'h1, 1'h1, 32'hffffffff, 32'h0}, '{8'h0d, 1'h0, 1'h0, 32'h0, 32'h03ffffff},
      '{8'h27, 1'h1, 1'h1, 32'hffffff76, 32'h0}, '{8'h27, 1'h0, 1'h0, 32'h0, 32'h76},
      '{8'h27, 1'h1, 1'h0, 32'hd, 32'h0}, '{8'h27, 1'h0, 1'h0, 32'h0, 32'h75},
      '{8'h31, 1'h0, 1'h0, 32'h0, 32'h0}};
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    foreach (rows[i]) begin
      acc(rows[i].a, rows[i].w, rows[i].u, rows[i].d);
      if (!rows[i].w) chk("row", q, rows[i].e);
      else chk("ack", 32'($isunknown(q)), 32'h0);
    end
    chk("ctl", 32'({inactive_count_sel, loop_mode}), 32'h1d);
    for (int c = 0; c < 4; c++) begin
      acc(8'h27, 1'h1, 1'h0, 32'(c));
      chk("mode", 32'({mode_active, mode_sleep, duty_cycled_low_power_operation}),
        32'({c == 0, c == 1, c == 2}));
    end
    s = '{x: 12'hc06, y: 12'h5a3, z: 12'h7ff, temp: 12'h9c1, hall_mode: 2'h2};
    sample_in <= s;
    sample_valid <= 1'h1;
    @(posedge clock);
    sample_valid <= 1'h0;
    host_u.read_sample(hi, lo);
    chk("hi", hi, {s.x[11:4], s.y[11:4], s.z[11:4], 2'h2, s.temp[11:6]});
    chk("lo", lo, {12'h0, s.x[3:0], s.y[3:0], s.z[3:0], s.hall_mode, s.temp[5:0]});
    acc(8'h28, 1'h0, 1'h0, 32'h0);
    chk("stale", q & 32'h80, 32'h0);
    // held event with persistent recording
    event_hold_en <= 1'h1;
    event_record_en <= 1'h1;
    @(posedge clock);
    event_level <= 1'h1;
    repeat (3) @(posedge clock);
    event_level <= 1'h0;
    repeat (3) @(posedge clock);
    chk("pin", 32'(event_pin_n), 32'h0);
    acc(8'h29, 1'h0, 1'h0, 32'h0);
    chk("wip", q & 32'h100000, 32'h100000);
    chk("start", 32'(n_start), 32'h1);
    persist_write_done <= 1'h1;
    @(posedge clock);
    persist_write_done <= 1'h0;
    acc(8'h29, 1'h0, 1'h0, 32'h0);
    chk("wip", q & 32'h100000, 32'h0);
    acc(8'h28, 1'h0, 1'h0, 32'h0);
    chk("held", q & 32'h40, 32'h40);
    acc(8'h28, 1'h1, 1'h1, 32'h40); // write one to release the held flag
    acc(8'h28, 1'h0, 1'h0, 32'h0);
    chk("clr", q & 32'h40, 32'h0);
    chk("pin", 32'(event_pin_n), 32'h1);
    // with the enable low the core must not react to the event
    clock_enable <= 1'h0;
    event_level <= 1'h1;
    repeat (3) @(posedge clock);
    chk("frozen", 32'(event_pin_n), 32'h1);
    clock_enable <= 1'h1;
    repeat (2) @(posedge clock);
    chk("thawed", 32'(event_pin_n), 32'h0);
    // mid-run reset: stored words, control, mode and pin go back to reset values
    event_level <= 1'h0;
    rst <= 1'h1;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    chk("rst ctl", 32'({inactive_count_sel, loop_mode}), 32'h0);
    chk("rst mode", 32'({mode_active, mode_sleep, duty_cycled_low_power_operation}),
      32'h4);
    chk("rst pin", 32'(event_pin_n), 32'h1);
    acc(8'h0d, 1'h0, 1'h0, 32'h0);
    chk("rst user", q, 32'h0);
    acc(8'h27, 1'h0, 1'h0, 32'h0);
    chk("rst ctrl word", q, 32'h0);
    finish_test();
  end
endmodule // fsrb_field_sensor_register_bank_tb_top
